/* hdl/rsc_auto_ack.sv */
// Boot chip-select auto-acknowledge wait-state counter
`timescale 1ns/1ns
`include "rsc_cfg.svh"

module rsc_auto_ack (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       aa_enable,
    input  wire logic       cycle_active,
    input  wire logic       ext_ack,
    output logic            auto_ack
);

    logic [5:0] wait_cnt_reg;
    logic       auto_ack_reg;

    // ****************************************
    // Wait-state counting
    // ****************************************

    // Counts wait states of an open cycle, clears when it ends
    always_ff @(posedge sys_clk) begin
        if (reset || !cycle_active || ext_ack || auto_ack_reg) begin
            wait_cnt_reg <= `RSC_AA_CNT_RESET;
        end else if (wait_cnt_reg != `RSC_AA_WAIT_STATES) begin
            wait_cnt_reg <= wait_cnt_reg + `RSC_AA_CNT_ONE;
        end
    end

    // One-cycle termination after the full wait-state count
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            auto_ack_reg <= 1'b0;
        end else begin
            auto_ack_reg <= aa_enable && cycle_active && !ext_ack && !auto_ack_reg
                            && (wait_cnt_reg == `RSC_AA_WAIT_STATES);
        end
    end

    assign auto_ack = auto_ack_reg;

    // ****************************************
    // Checks
    // ****************************************

    a_auto_ack_count: assert property (@(posedge sys_clk) disable iff (reset)
        auto_ack |-> $past(wait_cnt_reg) == `RSC_AA_WAIT_STATES && $past(aa_enable))
        else $error("auto acknowledge before wait states elapsed");

endmodule

/* hdl/rsc_loader.sv */
// Reset input handling and reset-time strap capture
`timescale 1ns/1ns
`include "rsc_cfg.svh"

module rsc_loader (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        reset_input_n,
    input  wire logic        pll_locked,
    input  wire logic [12:0] ad_in,
    input  wire logic        exp_reset_release,
    input  wire logic [3:0]  byte_strobe_req_n,
    input  wire logic [1:0]  transfer_size_code,
    input  wire logic [1:0]  local_low_address_bits,
    input  wire logic        boot_chip_select_n,
    input  wire logic        boot_write,
    input  wire logic        boot_ext_ack,
    output logic             reset_output_n,
    output logic             pll_hold,
    output logic [4:0]       clock_ratio_strap,
    output logic             ratio_reserved,
    output logic [1:0]       core_to_mem_mult,
    output logic             byte_strobe_function_strap,
    output logic             bus_mode_strap,
    output logic             local_ad_carries_addr,
    output logic             expansion_carries_addr,
    output logic             expansion_bus_available,
    output logic             byte_enable_mode_field,
    output logic             auto_acknowledge_field,
    output logic [3:0]       byte_strobes,
    output logic             boot_auto_ack,
    output logic             expansion_bus_reset_n
);

    rsc_pkg::rsc_state_t state_reg;
    rsc_pkg::rsc_state_t state_next;
    logic       reset_input_n_prev_reg;
    logic       reset_input_n_rise;
    logic       reset_output_n_n_reg;
    logic       pll_hold_reg;
    logic [4:0] ratio_reg;
    logic       reserved_reg;
    logic [1:0] mult_reg;
    logic       bstrobe_reg;
    logic       busmode_reg;
    logic       boot_be_reg;
    logic       boot_aa_reg;
    logic [3:0] strobes_reg;
    logic [3:0] strobes_next;
    logic       exp_rst_n_reg;

    // ****************************************
    // Helpers
    // ****************************************

    // True for the two ratio codes the clock generator supports
    function automatic logic ratio_ok(input logic [4:0] code);
        ratio_ok = (code == `RSC_RATIO_FAST) || (code == `RSC_RATIO_SLOW);
    endfunction

    // ****************************************
    // Reset input edge detection
    // ****************************************

    // Previous reset input level; reset counts as an asserted input
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reset_input_n_prev_reg <= 1'b0;
        end else begin
            reset_input_n_prev_reg <= reset_input_n;
        end
    end

    assign reset_input_n_rise = reset_input_n && !reset_input_n_prev_reg;

    // ****************************************
    // Reset sequencing
    // ****************************************

    // Next state from the reset input and the PLL lock report
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rsc_pkg::RSC_RST_ACTIVE: begin
                if (reset_input_n_rise) begin
                    state_next = rsc_pkg::RSC_WAIT_LOCK;
                end
            end
            rsc_pkg::RSC_WAIT_LOCK: begin
                if (!reset_input_n) begin
                    state_next = rsc_pkg::RSC_RST_ACTIVE;
                end else if (pll_locked) begin
                    state_next = rsc_pkg::RSC_RUN;
                end
            end
            rsc_pkg::RSC_RUN: begin
                if (!reset_input_n) begin
                    state_next = rsc_pkg::RSC_RST_ACTIVE;
                end
            end
            default: begin
                state_next = rsc_pkg::RSC_RST_ACTIVE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= rsc_pkg::RSC_RST_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Reset output released only once lock is back
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reset_output_n_n_reg <= 1'b0;
        end else begin
            reset_output_n_n_reg <= (state_next == rsc_pkg::RSC_RUN);
        end
    end

    // Input low pulls the output low with no clock delay
    assign reset_output_n = reset_output_n_n_reg && reset_input_n;

    // PLL held for relock while the reset input is low
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pll_hold_reg <= 1'b1;
        end else begin
            pll_hold_reg <= !reset_input_n;
        end
    end

    assign pll_hold = pll_hold_reg;

    // ****************************************
    // Strap capture
    // ****************************************

    // Clock ratio straps, held until the next rising edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ratio_reg    <= `RSC_RATIO_RESET;
            reserved_reg <= 1'b1;
        end else if (reset_input_n_rise) begin
            ratio_reg    <= ad_in[`RSC_RATIO_HI:`RSC_RATIO_LO];
            reserved_reg <= !ratio_ok(ad_in[`RSC_RATIO_HI:`RSC_RATIO_LO]);
        end
    end

    // Core runs at a fixed multiple of the memory clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mult_reg <= `RSC_CORE_MULT;
        end else begin
            mult_reg <= `RSC_CORE_MULT;
        end
    end

    // Single-bit straps, ignored outside the rising edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bstrobe_reg <= `RSC_STRAP_RESET;
            busmode_reg <= `RSC_STRAP_RESET;
            boot_be_reg <= `RSC_STRAP_RESET;
            boot_aa_reg <= `RSC_STRAP_RESET;
        end else if (reset_input_n_rise) begin
            bstrobe_reg <= ad_in[`RSC_BSTROBE_BIT];
            busmode_reg <= ad_in[`RSC_BUSMODE_BIT];
            boot_be_reg <= ad_in[`RSC_BOOT_BE_BIT];
            boot_aa_reg <= ad_in[`RSC_BOOT_AA_BIT];
        end
    end

    assign clock_ratio_strap          = ratio_reg;
    assign ratio_reserved             = reserved_reg;
    assign core_to_mem_mult           = mult_reg;
    assign byte_strobe_function_strap = bstrobe_reg;
    assign bus_mode_strap             = busmode_reg;
    assign byte_enable_mode_field     = boot_be_reg;
    assign auto_acknowledge_field     = boot_aa_reg;

    // ****************************************
    // Bus mode routing
    // ****************************************

    // Address placement and expansion bus availability
    assign local_ad_carries_addr   = !busmode_reg;
    assign expansion_carries_addr  = busmode_reg;
    assign expansion_bus_available = !busmode_reg;

    // ****************************************
    // Byte strobe pins
    // ****************************************

    // Pin function from the byte-strobe strap and boot read gating
    always_comb begin
        strobes_next = byte_strobe_req_n;
        if (bstrobe_reg) begin
            strobes_next = {transfer_size_code, local_low_address_bits};
        end else if (!boot_chip_select_n && boot_be_reg && !boot_write) begin
            strobes_next = `RSC_STROBE_IDLE;
        end
    end

    // Registered strobe pins, negated during reset
    always_ff @(posedge sys_clk) begin
        if (reset || !reset_output_n) begin
            strobes_reg <= `RSC_STROBE_IDLE;
        end else begin
            strobes_reg <= strobes_next;
        end
    end

    assign byte_strobes = strobes_reg;

    // ****************************************
    // Boot auto-acknowledge
    // ****************************************

    // Wait-state counter for the boot chip-select
    rsc_auto_ack u_auto_ack (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .aa_enable    (boot_aa_reg),
        .cycle_active (!boot_chip_select_n && reset_output_n),
        .ext_ack      (boot_ext_ack),
        .auto_ack     (boot_auto_ack)
    );

    // ****************************************
    // Expansion bus reset
    // ****************************************

    // Held low after reset; device reset wins over a release
    always_ff @(posedge sys_clk) begin
        if (reset || !reset_output_n) begin
            exp_rst_n_reg <= 1'b0;
        end else if (exp_reset_release) begin
            exp_rst_n_reg <= 1'b1;
        end
    end

    assign expansion_bus_reset_n = exp_rst_n_reg;

    // ****************************************
    // Checks
    // ****************************************

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence seq_reset_input_n_rise;
        !reset_input_n ##1 reset_input_n;
    endsequence

    sequence seq_lock_seen;
        (state_reg == rsc_pkg::RSC_WAIT_LOCK) && reset_input_n && pll_locked;
    endsequence

    a_reset_output_n_follows_reset_input_n: assert property (
        !reset_input_n |-> !reset_output_n)
        else $error("reset output not asserted with reset input");

    a_reset_output_n_hold_unlocked: assert property (
        (state_reg == rsc_pkg::RSC_WAIT_LOCK) && !pll_locked |=> !reset_output_n)
        else $error("reset output released before lock");

    a_reset_output_n_release_lock: assert property (
        seq_lock_seen ##1 reset_input_n |-> reset_output_n)
        else $error("reset output not released after lock");

    a_ratio_capture: assert property (
        seq_reset_input_n_rise |=> clock_ratio_strap == $past(ad_in[`RSC_RATIO_HI:`RSC_RATIO_LO]))
        else $error("ratio strap not captured at rising edge");

    a_ratio_reserved: assert property (
        seq_reset_input_n_rise |=> ratio_reserved == !ratio_ok(clock_ratio_strap))
        else $error("reserved ratio flag wrong");

    a_straps_held: assert property (
        !reset_input_n_rise |=> $stable({ratio_reg, bstrobe_reg, busmode_reg, boot_be_reg, boot_aa_reg}))
        else $error("strap state changed outside the rising edge");

    a_strobe_split: assert property (
        bstrobe_reg && reset_output_n ##1 reset_output_n
        |-> byte_strobes == $past({transfer_size_code, local_low_address_bits}))
        else $error("strobe pins not carrying size and address");

    a_boot_read_gate: assert property (
        !bstrobe_reg && boot_be_reg && !boot_chip_select_n && !boot_write
        |=> byte_strobes == `RSC_STROBE_IDLE)
        else $error("boot strobe asserted on read");

    a_exp_unavailable: assert property (
        busmode_reg |-> !expansion_bus_available && expansion_carries_addr)
        else $error("expansion bus available in non-multiplexed mode");

    a_exp_reset_held: assert property (
        !reset_output_n |=> !expansion_bus_reset_n)
        else $error("expansion reset released during device reset");

endmodule

/* include/rsc_cfg.svh */
// Constants for the reset strap configuration loader
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ****************************************
// Strap pin positions on the address/data lines
// ****************************************
`define RSC_AD_W           13
`define RSC_RATIO_HI       12
`define RSC_RATIO_LO       8
`define RSC_BSTROBE_BIT    5
`define RSC_BUSMODE_BIT    4
`define RSC_BOOT_BE_BIT    3
`define RSC_BOOT_AA_BIT    2

// ****************************************
// Clock ratio codes and clock relations
// ****************************************
`define RSC_RATIO_W        5
`define RSC_RATIO_FAST     5'h03
`define RSC_RATIO_SLOW     5'h05
`define RSC_RATIO_RESET    5'h00
`define RSC_CORE_MULT      2'h2

// ****************************************
// Boot chip-select auto-acknowledge
// ****************************************
`define RSC_AA_WAIT_STATES 6'h3f
`define RSC_AA_CNT_RESET   6'h00
`define RSC_AA_CNT_ONE     6'h01

// ****************************************
// Reset values of strap-derived state
// ****************************************
`define RSC_STRAP_RESET    1'h0
`define RSC_STROBE_IDLE    4'hf

`endif

/* include/rsc_pkg.sv */
// Types for the reset strap configuration loader
package rsc_pkg;

    // ****************************************
    // Reset sequencing states
    // ****************************************
    typedef enum logic [1:0] {
        RSC_RST_ACTIVE = 2'b00,
        RSC_WAIT_LOCK  = 2'b01,
        RSC_RUN        = 2'b10
    } rsc_state_t;

endpackage

/* verif/rsc_board_model.sv */
// Board model: external reset source, strap resistors and PLL lock report
`timescale 1ns/1ns

module rsc_board_model #(
    parameter int LOCK_DELAY = 4
) (
    input  wire logic        sys_clk,
    input  wire logic        hold_reset,
    input  wire logic [12:0] strap_val,
    output logic             reset_input_n,
    output logic [12:0]      ad_in,
    output logic             pll_locked
);

    logic [7:0] lock_cnt = 8'h00;

    // ****************************************
    // Reset source and strap lines
    // ****************************************
    // Straps stay put while reset is low and for the cycle of the rising edge,
    // after that the lines carry bus traffic that changes every cycle
    initial begin
        reset_input_n = 1'b0;
        ad_in         = 13'h0000;
        forever begin
            @(negedge sys_clk);
            if (hold_reset || !reset_input_n) begin
                ad_in <= strap_val;
            end else begin
                ad_in <= ~ad_in;
            end
            reset_input_n <= !hold_reset;
        end
    end

    // ****************************************
    // PLL lock
    // ****************************************
    // Lock is lost while reset is low and returns a few cycles later
    always @(posedge sys_clk) begin
        if (!reset_input_n) begin
            lock_cnt <= 8'h00;
        end else if (lock_cnt != 8'(LOCK_DELAY)) begin
            lock_cnt <= lock_cnt + 8'h01;
        end
    end

    assign pll_locked = (lock_cnt == 8'(LOCK_DELAY));

endmodule

/* verif/tb_top.sv */
// Self-checking testbench for the reset strap configuration loader
`timescale 1ns/1ns
`include "rsc_cfg.svh"

module tb_top;

    logic        sys_clk;
    logic        reset;
    logic        hold_reset;
    logic [12:0] strap_val;
    logic        reset_input_n;
    logic [12:0] ad_in;
    logic        pll_locked;
    logic        exp_reset_release;
    logic [3:0]  byte_strobe_req_n;
    logic [1:0]  transfer_size_code;
    logic [1:0]  local_low_address_bits;
    logic        boot_chip_select_n;
    logic        boot_write;
    logic        boot_ext_ack;
    logic        reset_output_n;
    logic        pll_hold;
    logic [4:0]  clock_ratio_strap;
    logic        ratio_reserved;
    logic [1:0]  core_to_mem_mult;
    logic        byte_strobe_function_strap;
    logic        bus_mode_strap;
    logic        local_ad_carries_addr;
    logic        expansion_carries_addr;
    logic        expansion_bus_available;
    logic        byte_enable_mode_field;
    logic        auto_acknowledge_field;
    logic [3:0]  byte_strobes;
    logic        boot_auto_ack;
    logic        expansion_bus_reset_n;
    int          errors;
    int          comparisons;
    int          cycles;

    // ****************************************
    // Clock, instances and timeout
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    rsc_board_model #(.LOCK_DELAY(4)) board (
        .sys_clk(sys_clk), .hold_reset(hold_reset), .strap_val(strap_val),
        .reset_input_n(reset_input_n), .ad_in(ad_in), .pll_locked(pll_locked));

    rsc_loader uut (
        .sys_clk(sys_clk), .reset(reset), .reset_input_n(reset_input_n), .pll_locked(pll_locked),
        .ad_in(ad_in), .exp_reset_release(exp_reset_release), .byte_strobe_req_n(byte_strobe_req_n),
        .transfer_size_code(transfer_size_code), .local_low_address_bits(local_low_address_bits),
        .boot_chip_select_n(boot_chip_select_n), .boot_write(boot_write), .boot_ext_ack(boot_ext_ack),
        .reset_output_n(reset_output_n), .pll_hold(pll_hold), .clock_ratio_strap(clock_ratio_strap),
        .ratio_reserved(ratio_reserved), .core_to_mem_mult(core_to_mem_mult),
        .byte_strobe_function_strap(byte_strobe_function_strap), .bus_mode_strap(bus_mode_strap),
        .local_ad_carries_addr(local_ad_carries_addr), .expansion_carries_addr(expansion_carries_addr),
        .expansion_bus_available(expansion_bus_available), .byte_enable_mode_field(byte_enable_mode_field),
        .auto_acknowledge_field(auto_acknowledge_field), .byte_strobes(byte_strobes),
        .boot_auto_ack(boot_auto_ack), .expansion_bus_reset_n(expansion_bus_reset_n));

    // Cuts a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            close_out();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    // Verdict and end of run
    task automatic close_out();
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One cycle, landing just after the falling edge
    task automatic tick();
        @(negedge sys_clk);
        #1;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Full reset input pulse with a strap pattern, then checks of the captured state
    task automatic boot(input logic [12:0] s);
        int n;
        strap_val = s;
        hold_reset = 1'b1;
        tick();
        check("reset_output_n", 16'h0000, 16'(reset_output_n));
        exp_reset_release = 1'b1;
        tick();
        check("expansion_bus_reset_n", 16'h0000, 16'(expansion_bus_reset_n));
        check("pll_hold", 16'h0001, 16'(pll_hold));
        tick();
        exp_reset_release = 1'b0;
        hold_reset = 1'b0;
        tick();
        n = 0;
        while (pll_locked !== 1'b1 && n < 20) begin
            check("reset_output_n", 16'h0000, 16'(reset_output_n));
            tick();
            n++;
        end
        check("reset_output_n", 16'h0000, 16'(reset_output_n));
        tick();
        check("reset_output_n", 16'h0001, 16'(reset_output_n));
        check("clock_ratio_strap", 16'(s[12:8]), 16'(clock_ratio_strap));
        check("ratio_reserved", 16'(!(s[12:8] == `RSC_RATIO_FAST || s[12:8] == `RSC_RATIO_SLOW)),
              16'(ratio_reserved));
        check("core_to_mem_mult", 16'(`RSC_CORE_MULT), 16'(core_to_mem_mult));
        check("pll_hold", 16'h0000, 16'(pll_hold));
        check("byte_strobe_function_strap", 16'(s[5]), 16'(byte_strobe_function_strap));
        check("bus_mode_strap", 16'(s[4]), 16'(bus_mode_strap));
        check("carries_addr", 16'({!s[4], s[4]}), 16'({local_ad_carries_addr, expansion_carries_addr}));
        check("expansion_bus_available", 16'(!s[4]), 16'(expansion_bus_available));
        check("byte_enable_mode_field", 16'(s[3]), 16'(byte_enable_mode_field));
        check("auto_acknowledge_field", 16'(s[2]), 16'(auto_acknowledge_field));
        check("expansion_bus_reset_n", 16'h0000, 16'(expansion_bus_reset_n));
        repeat (5) tick();
        check("held_straps", 16'({s[12:8], s[5:2]}), 16'({clock_ratio_strap, byte_strobe_function_strap,
              bus_mode_strap, byte_enable_mode_field, auto_acknowledge_field}));
    endtask

    // One boot cycle kind, byte strobes looked at one cycle later
    task automatic strobe(input logic cs_n, input logic wr, input logic [3:0] exp);
        boot_chip_select_n = cs_n;
        boot_write = wr;
        tick();
        check("byte_strobes", 16'(exp), 16'(byte_strobes));
    endtask

    // Boot read held open; measures cycles until the automatic acknowledge
    task automatic aa_run(input logic ack, input int exp_n);
        int n;
        // Close any cycle left open so the count starts from zero
        boot_chip_select_n = 1'b1;
        tick();
        boot_chip_select_n = 1'b0;
        boot_write = 1'b0;
        boot_ext_ack = ack;
        n = 0;
        while (boot_auto_ack !== 1'b1 && n < 70) begin
            tick();
            n++;
        end
        check("auto_ack_delay", 16'(exp_n), 16'(n));
        tick();
        check("boot_auto_ack", 16'h0000, 16'(boot_auto_ack));
        boot_chip_select_n = 1'b1;
        boot_ext_ack = 1'b0;
        tick();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        errors = 0;
        comparisons = 0;
        cycles = 0;
        reset = 1'b1;
        hold_reset = 1'b1;
        strap_val = 13'h0000;
        exp_reset_release = 1'b0;
        byte_strobe_req_n = 4'h6;
        transfer_size_code = 2'h2;
        local_low_address_bits = 2'h1;
        boot_chip_select_n = 1'b1;
        boot_write = 1'b0;
        boot_ext_ack = 1'b0;
        repeat (12) @(posedge sys_clk);
        tick();
        reset = 1'b0;
        check("byte_strobes", 16'(`RSC_STROBE_IDLE), 16'(byte_strobes));
        check("expansion_bus_reset_n", 16'h0000, 16'(expansion_bus_reset_n));
        // Fast ratio, split strobes, multiplexed bus, auto acknowledge on
        boot(13'h032c);
        strobe(1'b0, 1'b0, 4'h9);
        aa_run(1'b0, int'(`RSC_AA_WAIT_STATES) + 1);
        aa_run(1'b1, 70);
        exp_reset_release = 1'b1;
        tick();
        exp_reset_release = 1'b0;
        check("expansion_bus_reset_n", 16'h0001, 16'(expansion_bus_reset_n));
        // Slow ratio, byte enables, non-multiplexed bus, strobes only on writes
        boot(13'h051c);
        strobe(1'b0, 1'b0, 4'hf);
        strobe(1'b0, 1'b1, 4'h6);
        // Reserved ratio codes, auto acknowledge off
        boot(13'h1f20);
        aa_run(1'b0, 70);
        boot(13'h0000);
        strobe(1'b0, 1'b0, 4'h6);
        close_out();
    end

endmodule
